// *** flag_sync.sv ***
// two-flop synchroniser for a bundle of comparator flags
`timescale 1ns/100ps
module flag_sync
#(
  parameter int unsigned WIDTH = 10
)
(
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stage1_reg <= '0;
      sync_o     <= '0;
    end
    else
    begin
      stage1_reg <= async_i;
      sync_o     <= stage1_reg;
    end
  end

endmodule : flag_sync

// *** supply_seq_pkg.sv ***
// constants, state encoding and carrier structs for the supply start-up sequencer
package supply_seq_pkg;

  // start_settle_delay: 100 us, fixed here since no figure is given
  localparam int unsigned CLK_FREQ_HZ       = 50_000_000;
  localparam int unsigned SETTLE_DELAY_US   = 100;
  localparam int unsigned SETTLE_CYCLES     =
    (SETTLE_DELAY_US * (CLK_FREQ_HZ / 1_000_000) < 1) ? 1 :
    SETTLE_DELAY_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned SETTLE_CNT_W      = 16;
  localparam int unsigned SYNC_STAGES       = 2;
  localparam int unsigned CMP_W             = 10;

  // comparator bit positions inside cmp_s when flattened
  localparam int unsigned CMP_SUP_ON        = 9;

  typedef enum logic [4:0] {
    ST_CHARGE = 5'h01,
    ST_INIT   = 5'h02,
    ST_SETTLE = 5'h04,
    ST_RUN    = 5'h08,
    ST_SELF   = 5'h10
  } seq_state_e;

  // comparator flags, all asynchronous at the pins
  typedef struct packed {
    logic sup_above_on;      // supply at or above 9.5 V
    logic sup_above_low;     // supply above 9.4 V
    logic sup_above_run;     // supply above 7.5 V
    logic sup_above_min;     // supply above 6.5 V
    logic ss_above_offset;   // soft-start above 1.35 V
    logic ss_above_precharge;// soft-start above 0.5 V
    logic fault_shutdown_pin;// high when clear
    logic over_temp;         // high on over-temperature
    logic line_undervoltage_input; // high when line within limits
    logic aux_present;       // auxiliary supply has taken over
  } cmp_s;

  typedef struct packed {
    logic charge_source_on;
    logic reference_on;
    logic internal_enable;
    logic main_switch_drive;
    logic clamp_switch_drive;
    logic soft_start_clamp;
    logic soft_start_precharge;
    logic register_clear;
    logic self_supply_mode;
    logic run_threshold_sel;
  } ctl_s;

  localparam ctl_s CTL_RESET = '{
    charge_source_on:     1'b1,
    reference_on:         1'b0,
    internal_enable:      1'b0,
    main_switch_drive:    1'b0,
    clamp_switch_drive:   1'b0,
    soft_start_clamp:     1'b1,
    soft_start_precharge: 1'b0,
    register_clear:       1'b0,
    self_supply_mode:     1'b0,
    run_threshold_sel:    1'b0
  };

endpackage : supply_seq_pkg

// *** supply_startup_sequencer.sv ***
// supply start-up sequencer: charge source, reference, enable and drive gating
// How it works
// - charge source on until supply reaches on level
// - reference on above 7.5 V, again after collapse
// - at on level: source off, clear, precharge soft-start
// - init completes only with all faults clear
// - during init, recharge at 9.4 V to on
// - wait settle delay before asserting enable
// - after enable, undervoltage level drops to 7.5 V
// - main drive held low during init
// - clamp drive high once on level reached
// - main pulses only after soft-start above offset
// - soft-start clamped while enable is low
// - init end switches charge source off
// - supply at 7.5 V after init, aux absent, enters self-supply
// - self-supply cycles source between 9.4 and 9.5
// - collapse to 6.5 V: reference off, full restart
`timescale 1ns/100ps
module supply_startup_sequencer
(
  input  wire logic               sys_clk_i,
  input  wire logic               reset_n_i,
  input  wire supply_seq_pkg::cmp_s cmp_i,
  input  wire logic               pwm_pulse_i,
  output logic                    charge_source_on_o,
  output logic                    reference_on_o,
  output logic                    internal_enable_o,
  output logic                    main_switch_drive_o,
  output logic                    clamp_switch_drive_o,
  output logic                    soft_start_clamp_o,
  output logic                    soft_start_precharge_o,
  output logic                    register_clear_o,
  output logic                    self_supply_mode_o,
  output logic                    run_threshold_sel_o,
  output logic [4:0]              state_o
);

  typedef struct packed {
    supply_seq_pkg::seq_state_e        st;
    supply_seq_pkg::ctl_s              ctl;
    logic [supply_seq_pkg::SETTLE_CNT_W-1:0] cnt;
    logic                              ref_on;
  } seq_s;

  localparam logic [supply_seq_pkg::SETTLE_CNT_W-1:0] SETTLE_LAST =
    supply_seq_pkg::SETTLE_CNT_W'(supply_seq_pkg::SETTLE_CYCLES - 1);

  supply_seq_pkg::cmp_s cmp_sync;
  seq_s                 state_reg;
  seq_s                 state_next;
  logic                 faults_clear;

  flag_sync
  #(
    .WIDTH (supply_seq_pkg::CMP_W)
  )
  u_sync
  (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (cmp_i),
    .sync_o    (cmp_sync)
  );

  assign faults_clear = cmp_sync.fault_shutdown_pin & ~cmp_sync.over_temp &
                        cmp_sync.line_undervoltage_input;

  // hysteretic source control shared by init and self-supply; between the
  // two levels the source keeps its last state, which gives the hysteresis
  function automatic logic hiccup_source
  (
    input logic                 on_now,
    input supply_seq_pkg::cmp_s flags
  );
    logic result;
    result = on_now;
    if (!flags.sup_above_low)
      result = 1'b1;
    else if (flags.sup_above_on)
      result = 1'b0;
    return result;
  endfunction : hiccup_source

  always_comb
  begin
    state_next = state_reg;
    state_next.ctl.register_clear = 1'b0;

    // reference follows the 7.5 V crossing, dropped only at collapse
    if (cmp_sync.sup_above_run)
      state_next.ref_on = 1'b1;

    unique case (state_reg.st)
      supply_seq_pkg::ST_CHARGE:
      begin
        if (cmp_sync.sup_above_on)
        begin
          state_next.st = supply_seq_pkg::ST_INIT;
          state_next.ctl.charge_source_on = 1'b0;
          state_next.ctl.register_clear = 1'b1;
          state_next.ctl.soft_start_precharge = 1'b1;
          state_next.ctl.clamp_switch_drive = 1'b1;
        end
      end
      supply_seq_pkg::ST_INIT,
      supply_seq_pkg::ST_SETTLE:
      begin
        // hiccup between 9.4 and 9.5 while waiting on faults
        state_next.ctl.charge_source_on =
          hiccup_source(state_reg.ctl.charge_source_on, cmp_sync);
        if (cmp_sync.ss_above_precharge)
          state_next.ctl.soft_start_precharge = 1'b0;
        if (!faults_clear || !cmp_sync.ss_above_precharge)
        begin
          state_next.st  = supply_seq_pkg::ST_INIT;
          state_next.cnt = '0;
        end
        else if (state_reg.st == supply_seq_pkg::ST_INIT)
        begin
          state_next.st  = supply_seq_pkg::ST_SETTLE;
          state_next.cnt = '0;
        end
        else if (state_reg.cnt == SETTLE_LAST)
        begin
          state_next.st = supply_seq_pkg::ST_RUN;
          state_next.ctl.internal_enable   = 1'b1;
          state_next.ctl.run_threshold_sel = 1'b1;
          state_next.ctl.charge_source_on  = 1'b0;
          state_next.ctl.soft_start_clamp  = 1'b0;
        end
        else
          state_next.cnt = state_reg.cnt + 1'b1;
      end
      supply_seq_pkg::ST_RUN:
      begin
        if (!cmp_sync.sup_above_run && !cmp_sync.aux_present)
        begin
          state_next.st = supply_seq_pkg::ST_SELF;
          state_next.ctl.charge_source_on = 1'b1;
          state_next.ctl.self_supply_mode = 1'b1;
        end
      end
      supply_seq_pkg::ST_SELF:
      begin
        if (cmp_sync.aux_present)
        begin
          state_next.st = supply_seq_pkg::ST_RUN;
          state_next.ctl.charge_source_on = 1'b0;
          state_next.ctl.self_supply_mode = 1'b0;
        end
        else
          state_next.ctl.charge_source_on =
            hiccup_source(state_reg.ctl.charge_source_on, cmp_sync);
      end
      default:
        state_next.st = supply_seq_pkg::ST_CHARGE;
    endcase

    // main drive gated by enable and soft-start offset
    state_next.ctl.main_switch_drive = state_next.ctl.internal_enable &
      cmp_sync.ss_above_offset & pwm_pulse_i;
    state_next.ctl.soft_start_clamp = ~state_next.ctl.internal_enable;

    // collapse overrides everything and restarts from charging
    if (!cmp_sync.sup_above_min)
    begin
      state_next     = '0;
      state_next.st  = supply_seq_pkg::ST_CHARGE;
      state_next.ctl = supply_seq_pkg::CTL_RESET;
      state_next.ref_on = 1'b0;
    end
    state_next.ctl.reference_on = state_next.ref_on;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg.st  <= supply_seq_pkg::ST_CHARGE;
      state_reg.ctl <= supply_seq_pkg::CTL_RESET;
      state_reg.cnt <= '0;
      state_reg.ref_on <= 1'b0;
    end
    else
      state_reg <= state_next;
  end

  assign charge_source_on_o     = state_reg.ctl.charge_source_on;
  assign reference_on_o         = state_reg.ctl.reference_on;
  assign internal_enable_o      = state_reg.ctl.internal_enable;
  assign main_switch_drive_o    = state_reg.ctl.main_switch_drive;
  assign clamp_switch_drive_o   = state_reg.ctl.clamp_switch_drive;
  assign soft_start_clamp_o     = state_reg.ctl.soft_start_clamp;
  assign soft_start_precharge_o = state_reg.ctl.soft_start_precharge;
  assign register_clear_o       = state_reg.ctl.register_clear;
  assign self_supply_mode_o     = state_reg.ctl.self_supply_mode;
  assign run_threshold_sel_o    = state_reg.ctl.run_threshold_sel;
  assign state_o                = state_reg.st;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_drive_needs_enable: assert property (
    main_switch_drive_o |-> internal_enable_o)
    else $error("main drive active without enable");
  a_drive_needs_ss: assert property (
    main_switch_drive_o |-> $past(cmp_sync.ss_above_offset))
    else $error("main drive before soft-start offset");
  a_clamp_when_off: assert property (
    !internal_enable_o |-> soft_start_clamp_o)
    else $error("soft-start not clamped while disabled");
  a_on_to_init: assert property (
    (state_o == 5'h01 && cmp_sync.sup_above_on && cmp_sync.sup_above_min)
      |=> (state_o == 5'h02 && !charge_source_on_o && register_clear_o
           && clamp_switch_drive_o))
    else $error("on level did not start init");
  a_fault_blocks: assert property (
    (state_o inside {5'h02, 5'h04} && !faults_clear
     && cmp_sync.sup_above_min) |=> (state_o == 5'h02 && !internal_enable_o))
    else $error("enable with fault present");
  a_init_recharge: assert property (
    (state_o == 5'h02 && !cmp_sync.sup_above_low && cmp_sync.sup_above_min)
      |=> charge_source_on_o)
    else $error("no recharge at low threshold");
  a_enable_thresh: assert property (
    $rose(internal_enable_o) |-> run_threshold_sel_o && !charge_source_on_o)
    else $error("run threshold not selected at enable");
  a_self_entry: assert property (
    (state_o == 5'h08 && !cmp_sync.sup_above_run && !cmp_sync.aux_present
     && cmp_sync.sup_above_min) |=> self_supply_mode_o && charge_source_on_o)
    else $error("self-supply not entered");
  a_collapse: assert property (
    !cmp_sync.sup_above_min |=> !reference_on_o && state_o == 5'h01)
    else $error("collapse did not restart");
  a_ref_on: assert property (
    (cmp_sync.sup_above_run && cmp_sync.sup_above_min) |=> reference_on_o)
    else $error("reference not enabled above run level");

  // collapse is left out of most antecedents: it overrides every other path
  a_charge_hold: assert property (
    (state_o == 5'h01 && !cmp_sync.sup_above_on && cmp_sync.sup_above_min)
      |=> (state_o == 5'h01 && charge_source_on_o))
    else $error("charge source dropped before on level");
  a_ref_hold: assert property (
    (reference_on_o && cmp_sync.sup_above_min)
      |=> reference_on_o)
    else $error("reference dropped without collapse");
  a_clear_pulse: assert property (
    register_clear_o
      |=> !register_clear_o)
    else $error("register clear longer than one cycle");
  a_precharge_start: assert property (
    $rose(register_clear_o)
      |-> (soft_start_precharge_o && state_o == 5'h02))
    else $error("precharge not started with init");
  a_init_stop: assert property (
    (state_o inside {5'h02, 5'h04} && cmp_sync.sup_above_on
     && cmp_sync.sup_above_low && cmp_sync.sup_above_min)
      |=> !charge_source_on_o)
    else $error("charge source left on at on level");
  a_enable_after: assert property (
    $rose(internal_enable_o)
      |-> ($past(state_o) == 5'h04))
    else $error("enable raised outside settle");
  a_clamp_hold: assert property (
    (clamp_switch_drive_o && cmp_sync.sup_above_min)
      |=> clamp_switch_drive_o)
    else $error("clamp drive dropped while running");
  a_pulse_follow: assert property (
    (internal_enable_o && cmp_sync.ss_above_offset && pwm_pulse_i
     && cmp_sync.sup_above_min) |=> main_switch_drive_o)
    else $error("main drive missing after soft-start offset");
  a_ss_released: assert property (
    internal_enable_o
      |-> !soft_start_clamp_o)
    else $error("soft-start clamped while enabled");
  a_run_no_charge: assert property (
    (state_o == 5'h08 && cmp_sync.sup_above_min
     && (cmp_sync.sup_above_run || cmp_sync.aux_present))
      |=> (state_o == 5'h08 && !charge_source_on_o))
    else $error("charge source on while running");
  a_self_exit: assert property (
    (state_o == 5'h10 && cmp_sync.aux_present && cmp_sync.sup_above_min)
      |=> (state_o == 5'h08 && !self_supply_mode_o))
    else $error("self-supply kept after takeover");
  a_self_on: assert property (
    (state_o == 5'h10 && !cmp_sync.sup_above_low && !cmp_sync.aux_present
     && cmp_sync.sup_above_min) |=> charge_source_on_o)
    else $error("self-supply source not on at low level");
  a_self_off: assert property (
    (state_o == 5'h10 && cmp_sync.sup_above_on && cmp_sync.sup_above_low
     && !cmp_sync.aux_present && cmp_sync.sup_above_min)
      |=> !charge_source_on_o)
    else $error("self-supply source not off at on level");
  a_collapse_ctl: assert property (
    !cmp_sync.sup_above_min
      |=> (!internal_enable_o && charge_source_on_o && soft_start_clamp_o))
    else $error("collapse did not restore start-up controls");
  // the first two edges after reset still show the flushed stages
  a_sync_delay: assert property (
    $past(reset_n_i, 2)
      |-> (cmp_sync == $past(cmp_i, 2)))
    else $error("comparator flags not delayed by two stages");

  c_enable: cover property ($rose(internal_enable_o));
  c_self: cover property ($rose(self_supply_mode_o));
  c_pulse: cover property ($rose(main_switch_drive_o));
  c_restart: cover property (reference_on_o ##1 !reference_on_o);
  c_hiccup: cover property (state_o == 5'h02 && $rose(charge_source_on_o));

endmodule : supply_startup_sequencer

// *** supply_startup_sequencer_test.sv ***
// self-checking bench for the supply start-up sequencer
`timescale 1ns/100ps
module supply_startup_sequencer_test;
  logic                 sys_clk_i   = 1'b0;
  logic                 reset_n_i   = 1'b0;
  supply_seq_pkg::cmp_s cmp_i       = '0;
  logic                 pwm_pulse_i = 1'b0;
  logic                 charge_source_on_o;
  logic                 reference_on_o;
  logic                 internal_enable_o;
  logic                 main_switch_drive_o;
  logic                 clamp_switch_drive_o;
  logic                 soft_start_clamp_o;
  logic                 soft_start_precharge_o;
  logic                 register_clear_o;
  logic                 self_supply_mode_o;
  logic                 run_threshold_sel_o;
  logic [4:0]           state_o;
  int                   failures    = 0;
  int                   check_count = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  supply_startup_sequencer dut_u
  (
    .sys_clk_i              (sys_clk_i),
    .reset_n_i              (reset_n_i),
    .cmp_i                  (cmp_i),
    .pwm_pulse_i            (pwm_pulse_i),
    .charge_source_on_o     (charge_source_on_o),
    .reference_on_o         (reference_on_o),
    .internal_enable_o      (internal_enable_o),
    .main_switch_drive_o    (main_switch_drive_o),
    .clamp_switch_drive_o   (clamp_switch_drive_o),
    .soft_start_clamp_o     (soft_start_clamp_o),
    .soft_start_precharge_o (soft_start_precharge_o),
    .register_clear_o       (register_clear_o),
    .self_supply_mode_o     (self_supply_mode_o),
    .run_threshold_sel_o    (run_threshold_sel_o),
    .state_o                (state_o)
  );

  // drive and sample 2 ns after the edge so updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask : step

  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic t_reset();
    check(state_o, supply_seq_pkg::ST_CHARGE);
    check(charge_source_on_o, 1'b1);
    check(soft_start_clamp_o, 1'b1);
    check(internal_enable_o, 1'b0);
    check(main_switch_drive_o, 1'b0);
    check(reference_on_o, 1'b0);
  endtask : t_reset

  task automatic t_power_up();
    cmp_i.sup_above_min = 1'b1;
    cmp_i.sup_above_run = 1'b1;
    cmp_i.over_temp     = 1'b1;
    step(4);
    check(reference_on_o, 1'b1);
    check(charge_source_on_o, 1'b1);
    cmp_i.sup_above_low = 1'b1;
    cmp_i.sup_above_on  = 1'b1;
    cmp_i.ss_above_offset = 1'b1;
    pwm_pulse_i         = 1'b1;
    step(3);
    check(register_clear_o, 1'b1);
    check(state_o, supply_seq_pkg::ST_INIT);
    check(charge_source_on_o, 1'b0);
    check(soft_start_precharge_o, 1'b1);
    check(clamp_switch_drive_o, 1'b1);
    step(1);
    check(register_clear_o, 1'b0);
    check(main_switch_drive_o, 1'b0);
    cmp_i.sup_above_on = 1'b0;
    cmp_i.ss_above_offset = 1'b0;
    step(4);
    check(charge_source_on_o, 1'b0);
    cmp_i.sup_above_low = 1'b0;
    step(4);
    check(charge_source_on_o, 1'b1);
    cmp_i.sup_above_low = 1'b1;
    cmp_i.sup_above_on  = 1'b1;
    step(4);
    check(charge_source_on_o, 1'b0);
    cmp_i.ss_above_precharge = 1'b1;
    // each fault input alone must keep the sequence in init
    for (int i = 0; i < 3; i++)
    begin
      cmp_i.fault_shutdown_pin      = (i != 0);
      cmp_i.over_temp               = (i == 1);
      cmp_i.line_undervoltage_input = (i != 2);
      step(4);
      check(state_o, supply_seq_pkg::ST_INIT);
    end
    check(soft_start_precharge_o, 1'b0);
    cmp_i.line_undervoltage_input = 1'b1;
    step(6);
    check(state_o, supply_seq_pkg::ST_SETTLE);
    // a fault during settle must send the sequence back to init
    cmp_i.fault_shutdown_pin = 1'b0;
    step(4);
    check(state_o, supply_seq_pkg::ST_INIT);
    cmp_i.fault_shutdown_pin = 1'b1;
    step(3 + supply_seq_pkg::SETTLE_CYCLES - 10);
    check(state_o, supply_seq_pkg::ST_SETTLE);
    check(internal_enable_o, 1'b0);
    check(soft_start_clamp_o, 1'b1);
    // supply dips during settle so the source is on when enable comes
    cmp_i.sup_above_on  = 1'b0;
    cmp_i.sup_above_low = 1'b0;
    step(4);
    check(charge_source_on_o, 1'b1);
    step(16);
    check(state_o, supply_seq_pkg::ST_RUN);
    check(charge_source_on_o, 1'b0);
    check(internal_enable_o, 1'b1);
    check(run_threshold_sel_o, 1'b1);
    check(soft_start_clamp_o, 1'b0);
    check(main_switch_drive_o, 1'b0);
    cmp_i.ss_above_offset = 1'b1;
    step(4);
    check(main_switch_drive_o, 1'b1);
    pwm_pulse_i = 1'b0;
    step(4);
    check(main_switch_drive_o, 1'b0);
  endtask : t_power_up

  task automatic t_self_supply();
    cmp_i.sup_above_on  = 1'b0;
    cmp_i.sup_above_low = 1'b0;
    cmp_i.sup_above_run = 1'b0;
    step(4);
    check(state_o, supply_seq_pkg::ST_SELF);
    check(self_supply_mode_o, 1'b1);
    check(charge_source_on_o, 1'b1);
    cmp_i.sup_above_run = 1'b1;
    cmp_i.sup_above_low = 1'b1;
    cmp_i.sup_above_on  = 1'b1;
    step(4);
    check(charge_source_on_o, 1'b0);
    cmp_i.sup_above_on = 1'b0;
    step(4);
    check(charge_source_on_o, 1'b0);
    check(state_o, supply_seq_pkg::ST_SELF);
    cmp_i.sup_above_low = 1'b0;
    step(4);
    check(charge_source_on_o, 1'b1);
    cmp_i.aux_present = 1'b1;
    step(4);
    check(state_o, supply_seq_pkg::ST_RUN);
    check(self_supply_mode_o, 1'b0);
  endtask : t_self_supply

  task automatic t_collapse();
    cmp_i.sup_above_min = 1'b0;
    cmp_i.sup_above_run = 1'b0;
    step(4);
    check(reference_on_o, 1'b0);
    check(state_o, supply_seq_pkg::ST_CHARGE);
    check(internal_enable_o, 1'b0);
    check(charge_source_on_o, 1'b1);
    check(soft_start_clamp_o, 1'b1);
    cmp_i.sup_above_min = 1'b1;
    cmp_i.sup_above_run = 1'b1;
    step(4);
    check(reference_on_o, 1'b1);
    check(charge_source_on_o, 1'b1);
    cmp_i.sup_above_low = 1'b1;
    cmp_i.sup_above_on  = 1'b1;
    step(3);
    check(state_o, supply_seq_pkg::ST_INIT);
    check(register_clear_o, 1'b1);
    check(clamp_switch_drive_o, 1'b1);
  endtask : t_collapse

  // the settle count dominates the run; margin covers the rest
  initial
  begin
    repeat (supply_seq_pkg::SETTLE_CYCLES + 3000) @(posedge sys_clk_i);
    failures++;
    end_of_test();
  end

  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    #2;
    reset_n_i = 1'b1;
    step(1);
    t_reset();
    t_power_up();
    t_self_supply();
    t_collapse();
    end_of_test();
  end
endmodule : supply_startup_sequencer_test
